/* ifd_decoder.sv */
// instruction format decoder: one byte a cycle in, fields and length out
// assumes bytes start at an instruction boundary after reset, core clock
//
// Design decisions made here: the register addresses and the plain strobed port.
`default_nettype none

// Functional notes
// [RL1] opcode bytes then addressing, sib, disp, immediate
// [RL2] some addressing bytes pull in a sib byte
// [RL3] displacement of 8, 16 or 32 bits
// [RL4] immediate comes last and ends the instruction
// [RL5] extract width, direction and sign-extend bits
// [RL6] addressing byte splits into form and location
// [RL7] sib byte gives scale, index and base
// [RL8] two-bit and three-bit segment selectors
// [RL9] four-bit condition field
// [RL10] default sizes follow code segment size flag
// [RL11] real and v86 modes force 16-bit defaults
// [RL12] size prefixes toggle operand and address size
// [RL13] size prefixes act on one instruction only
// [RL14] prefix order never changes the result; here the last of two segment or two rep prefixes wins
// [RL15] narrow results keep upper bits
// [RL16] width bit picks byte or full size
// [RL17] 32-bit forms available in every mode
// [RL18] three-bit selector names eight registers
// [RL19] byte selectors 100-111 pick high bytes
// [RL20] segment codes 110 and 111 are invalid
// [RL21] sib follows location 100 under 32-bit addressing
// [RL22] report length and fields per instruction
module ifd_decoder
  import ifd_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        ce,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        byte_valid,
  input  wire logic [7:0]  byte_data,
  output logic             byte_ready,
  output logic             dec_valid,
  output var ifd_fields_s  dec_fields
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    ifd_state_e  state;
    ifd_attr_s   attr;
    logic        pfx_opsize;
    logic        pfx_adsize;
    logic [1:0]  cnt;
    ifd_fields_s work;
    logic [15:0] ctrl;
    logic [15:0] count;
    logic [15:0] rdata;
    logic        ready;
    logic        out_valid;
    ifd_fields_s out;
  } ifd_regs_s;

  ifd_regs_s r_ff;
  ifd_regs_s nxt_r;
  ifd_attr_s cls_attr;

  ifd_opc_class u_class (
    .two_byte (r_ff.state == ST_OPC2),
    .opc      (byte_data),
    .attr     (cls_attr)
  );

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [2:0] disp_bytes(input logic a32, input logic [1:0] md,
                                            input logic [2:0] rm, input logic [2:0] base,
                                            input logic sib);
    logic [2:0] n;
    n = 3'h0;
    if (md == 2'b01) begin
      n = 3'h1; // RL3
    end else if (md == 2'b10) begin
      n = a32 ? 3'h4 : 3'h2; // RL3
    end else if (md == 2'b00) begin
      if (!a32 && rm == RM_D16_ONLY) begin
        n = 3'h2;
      end else if (a32 && !sib && rm == BASE_D32_ONLY) begin
        n = 3'h4;
      end else if (a32 && sib && base == BASE_D32_ONLY) begin
        n = 3'h4;
      end
    end
    return n;
  endfunction : disp_bytes

  function automatic logic [2:0] imm_bytes(input ifd_imm_e k, input logic op32);
    logic [2:0] n;
    case (k)
      IMM_BYTE: n = 3'h1;
      IMM_FULL: n = op32 ? 3'h4 : 3'h2; // RL17
      IMM_WORD: n = 3'h2;
      default:  n = 3'h0;
    endcase
    return n;
  endfunction : imm_bytes

  // bytes a write may touch
  function automatic logic [3:0] dst_mask(input logic w, input logic op32, input logic [2:0] sel);
    logic [3:0] m;
    if (!w) begin
      m = sel[2] ? 4'h2 : 4'h1; // RL19
    end else begin
      m = op32 ? 4'hf : 4'h3; // RL16
    end
    return m; // RL15
  endfunction : dst_mask

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic       take;
    logic       done;
    logic       dflag;
    logic [2:0] nd;
    logic [2:0] ni;
    logic [2:0] sel;
    nxt_r = r_ff;
    take  = 1'b0;
    done  = 1'b0;
    dflag = 1'b0;
    nd    = 3'h0;
    ni    = 3'h0;
    sel   = 3'h0;
    nxt_r.out_valid = 1'b0;
    nxt_r.ready     = r_ff.ctrl[CTRL_EN_BIT];

    // real and v86 modes have no descriptor: flag reads 0
    dflag = (r_ff.ctrl[CTRL_MODE_LSB +: 2] == MODE_PROT) & r_ff.ctrl[CTRL_DFLAG_BIT]; // RL10 RL11
    // toggles commute: order is moot
    nxt_r.work.op32   = dflag ^ r_ff.pfx_opsize; // RL12 RL14
    nxt_r.work.addr32 = dflag ^ r_ff.pfx_adsize; // RL12 RL14

    // read data stands one cycle only
    nxt_r.rdata = 16'h0000;
    if (reg_wr && reg_addr == REG_CTRL) begin
      nxt_r.ctrl = reg_wdata;
    end
    if (reg_rd) begin
      case (reg_addr)
        REG_CTRL:   nxt_r.rdata = r_ff.ctrl;
        REG_STATUS: nxt_r.rdata = {12'h000, r_ff.state, r_ff.state != ST_OPC};
        REG_COUNT:  nxt_r.rdata = r_ff.count;
        REG_LAST:   nxt_r.rdata = {9'h000, r_ff.out.addr32, r_ff.out.op32, r_ff.out.length};
        default:    nxt_r.rdata = 16'h0000;
      endcase
    end

    take = byte_valid & r_ff.ready;
    if (take) begin
      nxt_r.work.length = r_ff.work.length + 5'h01;
      case (r_ff.state)
        ST_OPC, ST_OPC2: begin
          if (r_ff.state == ST_OPC && (byte_data == PFX_OPSIZE)) begin
            nxt_r.pfx_opsize = 1'b1; // RL13
          end else if (r_ff.state == ST_OPC && byte_data == PFX_ADSIZE) begin
            nxt_r.pfx_adsize = 1'b1; // RL13
          end else if (r_ff.state == ST_OPC && byte_data == PFX_LOCK) begin
            nxt_r.work.lock = 1'b1; // RL14
          end else if (r_ff.state == ST_OPC && byte_data[7:1] == 7'b1111001) begin
            nxt_r.work.rep = {1'b1, byte_data[0]};
          end else if (r_ff.state == ST_OPC &&
                       (byte_data == PFX_SEG_ES || byte_data == PFX_SEG_CS ||
                        byte_data == PFX_SEG_SS || byte_data == PFX_SEG_DS)) begin
            nxt_r.work.seg_ovr_valid = 1'b1;
            nxt_r.work.seg_ovr       = {1'b0, byte_data[4:3]};
          end else if (r_ff.state == ST_OPC &&
                       (byte_data == PFX_SEG_FS || byte_data == PFX_SEG_GS)) begin
            nxt_r.work.seg_ovr_valid = 1'b1;
            nxt_r.work.seg_ovr       = {2'b10, byte_data[0]};
          end else if (r_ff.state == ST_OPC && byte_data == OPC_ESCAPE) begin
            nxt_r.work.two_byte = 1'b1; // RL1
            nxt_r.state         = ST_OPC2;
          end else begin
            nxt_r.attr        = cls_attr;
            nxt_r.work.opcode = byte_data;
            nxt_r.work.w      = cls_attr.has_w ? byte_data[0] : 1'b1; // RL5
            nxt_r.work.d      = cls_attr.has_d & byte_data[1]; // RL5
            nxt_r.work.s      = cls_attr.has_s & byte_data[1]; // RL5
            nxt_r.work.cond_valid = cls_attr.has_cond;
            nxt_r.work.cond   = byte_data[3:0]; // RL9
            nxt_r.work.seg2_valid = cls_attr.has_seg2;
            nxt_r.work.seg_selector_two_bit = byte_data[4:3]; // RL8
            nxt_r.work.reg_field = byte_data[2:0]; // RL18
            ni = imm_bytes(cls_attr.imm, nxt_r.work.op32);
            nxt_r.work.imm_len = ni;
            nxt_r.cnt = 2'h0;
            if (cls_attr.has_modrm) begin
              nxt_r.state = ST_MODRM; // RL1
            end else if (ni != 3'h0) begin
              nxt_r.state = ST_IMM;
            end else begin
              done = 1'b1;
            end
          end
        end
        ST_MODRM: begin
          nxt_r.work.modrm_present = 1'b1;
          nxt_r.work.mode_field    = byte_data[7:6]; // RL6
          nxt_r.work.reg_field     = byte_data[5:3]; // RL6
          nxt_r.work.rm_field      = byte_data[2:0]; // RL6
          nxt_r.work.seg_selector_three_bit = byte_data[5:3]; // RL8
          nxt_r.work.seg3_valid = r_ff.attr.has_seg3 &
                                  (byte_data[5:3] <= SEG3_LAST_VALID); // RL20
          nd = disp_bytes(r_ff.work.addr32, byte_data[7:6], byte_data[2:0], 3'h0, 1'b0);
          if (r_ff.work.addr32 && byte_data[2:0] == RM_SIB && byte_data[7:6] != MOD_REG) begin
            nxt_r.state = ST_SIB; // RL2 RL21
          end else if (nd != 3'h0) begin
            nxt_r.work.disp_len = nd;
            nxt_r.state = ST_DISP; // RL3
          end else if (r_ff.work.imm_len != 3'h0) begin
            nxt_r.state = ST_IMM;
          end else begin
            done = 1'b1;
          end
        end
        ST_SIB: begin
          nxt_r.work.sib_present = 1'b1;
          nxt_r.work.scale = byte_data[7:6]; // RL7
          nxt_r.work.index = byte_data[5:3]; // RL7
          nxt_r.work.base  = byte_data[2:0]; // RL7
          nd = disp_bytes(1'b1, r_ff.work.mode_field, RM_SIB, byte_data[2:0], 1'b1); // RL2
          nxt_r.work.disp_len = nd;
          if (nd != 3'h0) begin
            nxt_r.state = ST_DISP; // RL3
          end else if (r_ff.work.imm_len != 3'h0) begin
            nxt_r.state = ST_IMM;
          end else begin
            done = 1'b1;
          end
        end
        ST_DISP: begin
          nxt_r.work.disp[8*r_ff.cnt +: 8] = byte_data; // RL3
          nxt_r.cnt = r_ff.cnt + 2'h1;
          if ({1'b0, r_ff.cnt} == r_ff.work.disp_len - 3'h1) begin
            nxt_r.cnt = 2'h0;
            if (r_ff.work.imm_len != 3'h0) begin
              nxt_r.state = ST_IMM; // RL4
            end else begin
              done = 1'b1;
            end
          end
        end
        ST_IMM: begin
          nxt_r.work.imm[8*r_ff.cnt +: 8] = byte_data;
          nxt_r.cnt = r_ff.cnt + 2'h1;
          if ({1'b0, r_ff.cnt} == r_ff.work.imm_len - 3'h1) begin
            done = 1'b1; // RL4
          end
        end
        default: begin
          nxt_r.state = ST_OPC;
        end
      endcase
    end

    if (done) begin
      // rm names the target only when d is clear and mod says register
      sel = (r_ff.attr.has_modrm && !nxt_r.work.d && nxt_r.work.mode_field == MOD_REG) ?
            nxt_r.work.rm_field : nxt_r.work.reg_field; // RL18
      nxt_r.work.dst_reg       = (nxt_r.work.w) ? sel : {1'b0, sel[1:0]}; // RL19
      nxt_r.work.dst_high_byte = ~nxt_r.work.w & sel[2]; // RL19
      nxt_r.work.dst_byte_mask = dst_mask(nxt_r.work.w, nxt_r.work.op32, sel); // RL15 RL16
      nxt_r.out       = nxt_r.work; // RL22
      nxt_r.out_valid = 1'b1; // RL22
      nxt_r.count     = r_ff.count + 16'h0001;
      nxt_r.state     = ST_OPC;
      nxt_r.cnt       = 2'h0;
      nxt_r.attr      = '0;
      nxt_r.work      = '0;
      // prefixes die with their instruction
      nxt_r.pfx_opsize = 1'b0; // RL13
      nxt_r.pfx_adsize = 1'b0; // RL13
      nxt_r.work.op32   = dflag;
      nxt_r.work.addr32 = dflag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  // ce low freezes all, the software port too
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      r_ff      <= '0;
      r_ff.ctrl <= CTRL_RESET;
    end else if (ce) begin
      r_ff <= nxt_r;
    end
  end

  assign reg_rdata  = r_ff.rdata;
  assign byte_ready = r_ff.ready;
  assign dec_valid  = r_ff.out_valid;
  assign dec_fields = r_ff.out;

endmodule : ifd_decoder

`default_nettype wire

/* ifd_decoder_asserts.sv */
// checker for ifd_decoder ports
// assumes one clock, sync active-high reset
`default_nettype none

module ifd_decoder_chk
  import ifd_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        ce,
  input wire logic [3:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        byte_valid,
  input wire logic        byte_ready,
  input wire logic        dec_valid,
  input wire ifd_fields_s dec_fields
);
  ifd_fields_s f;
  logic [5:0]  min_len;

  assign f       = dec_fields;
  assign min_len = 6'h1 + f.two_byte + f.modrm_present + f.sib_present + f.disp_len + f.imm_len;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  ////////////////////////////////////////
  sequence s_ctrl_rd;
    reg_rd && ce && reg_addr == REG_CTRL;
  endsequence

  property p_rd_idle;
    !(reg_rd && ce) |=> reg_rdata == 16'h0000;
  endproperty
  // ready lags enable by one cycle
  property p_en_ready;
    s_ctrl_rd |=> reg_rdata[CTRL_EN_BIT] == byte_ready;
  endproperty
  property p_cause;
    dec_valid |-> $past(byte_valid && byte_ready && ce);
  endproperty
  property p_hold;
    !dec_valid |-> $stable(dec_fields);
  endproperty
  property p_len;
    dec_valid |-> f.length >= 5'(min_len);
  endproperty
  property p_sib;
    dec_valid && f.modrm_present && f.mode_field != MOD_REG |->
      f.sib_present == (f.addr32 && f.rm_field == RM_SIB);
  endproperty
  property p_disp;
    dec_valid |-> f.disp_len inside {3'h0, 3'h1, 3'h2, 3'h4};
  endproperty
  property p_seg3;
    dec_valid && f.seg3_valid |-> f.seg_selector_three_bit <= SEG3_LAST_VALID;
  endproperty
  property p_cond;
    dec_valid && f.cond_valid |-> f.cond == f.opcode[3:0];
  endproperty
  property p_mask;
    dec_valid && f.modrm_present |-> f.dst_byte_mask ==
      (!f.w ? (f.dst_high_byte ? 4'h2 : 4'h1) : (f.op32 ? 4'hf : 4'h3));
  endproperty

  ////////////////////////////////////////
  a_rd_idle: assert property (p_rd_idle)
    else $error("stray read data");
  a_en_ready: assert property (p_en_ready)
    else $error("ready mismatch");
  a_cause: assert property (p_cause)
    else $error("done without a byte");
  a_hold: assert property (p_hold)
    else $error("fields changed");
  a_len: assert property (p_len)
    else $error("length too short");
  a_sib: assert property (p_sib)
    else $error("sib wrong");
  a_disp: assert property (p_disp)
    else $error("bad disp width");
  a_seg3: assert property (p_seg3)
    else $error("bad segment code");
  a_cond: assert property (p_cond)
    else $error("cond wrong");
  a_mask: assert property (p_mask)
    else $error("mask wrong");
endmodule : ifd_decoder_chk

bind ifd_decoder ifd_decoder_chk u_chk (
  .clk_sys(clk_sys), .reset(reset), .ce(ce), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .byte_valid(byte_valid), .byte_ready(byte_ready),
  .dec_valid(dec_valid), .dec_fields(dec_fields)
);

`default_nettype wire

/* ifd_fetch_model.sv */
// fetch-side byte source for the decoder
// assumes whole instructions are pushed; slow adds gaps
`default_nettype none

module ifd_fetch_model (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       ce,
  input  wire logic       slow,
  input  wire logic       byte_ready,
  output logic            byte_valid,
  output logic      [7:0] byte_data
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] q[$];
  logic       gap = 1'b0;

  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask : push

  initial begin
    byte_valid = 1'b0;
    byte_data  = 8'h00;
  end

  // a byte holds until taken; idle data flips
  always @(posedge clk_sys) begin
    gap <= ~gap;
    if (reset) begin
      byte_valid <= 1'b0;
    end else if (!byte_valid || (byte_ready && ce)) begin
      if (byte_valid) begin
        void'(q.pop_front());
      end
      if (q.size() != 0 && (!slow || gap)) begin
        byte_valid <= 1'b1;
        byte_data  <= q[0];
      end else begin
        byte_valid <= 1'b0;
        byte_data  <= ~byte_data;
      end
    end
  end
endmodule : ifd_fetch_model

`default_nettype wire

/* ifd_opc_class.sv */
// opcode class table: fields after an opcode, meaningful opcode bits
// assumes the caller flags bytes after the escape; combinational
`default_nettype none

module ifd_opc_class
  import ifd_pkg::*;
(
  input  wire logic       two_byte,
  input  wire logic [7:0] opc,
  output var ifd_attr_s   attr
);

  // common classes only; unknown one-byte codes decode as bare opcodes, unknown two-byte codes take an addressing byte
  always_comb begin
    attr = '0;
    if (!two_byte) begin
      if (opc[7:6] == 2'b00 && opc[2:1] != 2'b11) begin
        attr.has_modrm = ~opc[2];
        attr.imm       = opc[2] ? (opc[0] ? IMM_FULL : IMM_BYTE) : IMM_NONE;
        attr.has_w     = 1'b1;
        attr.has_d     = ~opc[2];
      end else if (opc[7:6] == 2'b00) begin
        attr.has_seg2 = ~opc[5];
      end else if (opc[7:5] == 3'b010 || opc[7:4] == 4'h9 || opc[7:4] == 4'hb) begin
        attr.has_opreg = 1'b1;
        attr.has_w     = opc[7:4] == 4'hb;
        attr.imm       = opc[7:4] != 4'hb ? IMM_NONE : (opc[3] ? IMM_FULL : IMM_BYTE);
      end else if (opc[7:4] == 4'h7) begin
        attr.imm      = IMM_BYTE;
        attr.has_cond = 1'b1;
      end else if (opc[7:2] == 6'b011010) begin
        attr.has_modrm = opc[0];
        attr.imm       = opc[1] ? IMM_BYTE : IMM_FULL;
        attr.has_s     = 1'b1;
      end else if (opc[7:2] == 6'b100000) begin
        attr.has_modrm = 1'b1;
        attr.imm       = opc[1:0] == 2'b01 ? IMM_FULL : IMM_BYTE;
        attr.has_w     = 1'b1;
        attr.has_s     = 1'b1;
      end else if (opc[7:4] == 4'h8) begin
        attr.has_modrm = 1'b1;
        attr.has_w     = ~opc[3] | ~opc[2];
        attr.has_d     = opc[3] & ~opc[2];
        attr.has_seg3  = opc == 8'h8c || opc == 8'h8e;
      end else if (opc[7:1] == 7'b1010100 || opc[7:1] == 7'b1100011) begin
        attr.has_modrm = opc[6];
        attr.imm       = opc[0] ? IMM_FULL : IMM_BYTE;
        attr.has_w     = 1'b1;
      end else if (opc[7:1] == 7'b1100000 || opc[7:2] == 6'b110100) begin
        attr.has_modrm = 1'b1;
        attr.imm       = opc[4] ? IMM_NONE : IMM_BYTE;
        attr.has_w     = 1'b1;
      end else if (opc == 8'hc2 || opc == 8'hca) begin
        attr.imm = IMM_WORD;
      end else if (opc == 8'he8 || opc == 8'he9) begin
        attr.imm = IMM_FULL;
      end else if (opc == 8'heb || opc[7:2] == 6'b111000) begin
        attr.imm = IMM_BYTE;
      end else if (opc[7:1] == 7'b1111011 || opc[7:1] == 7'b1111111) begin
        attr.has_modrm = 1'b1;
        attr.has_w     = 1'b1;
      end
    end else begin
      if (opc[7:4] == 4'h8) begin
        attr.imm      = IMM_FULL;
        attr.has_cond = 1'b1;
      end else if (opc[7:4] == 4'h9) begin
        attr.has_modrm = 1'b1;
        attr.has_cond  = 1'b1;
      end else if (opc[7:3] == 5'b11001 || opc == 8'h06 || opc == 8'h08 || opc == 8'h09) begin
        attr.has_opreg = opc[7];
      end else if (opc[7:1] == 7'b1010000 || opc[7:1] == 7'b1010100) begin
        attr.has_seg3 = 1'b1;
      end else begin
        attr.has_modrm = 1'b1;
        attr.imm       = (opc == 8'ha4 || opc == 8'hac || opc == 8'hba) ? IMM_BYTE : IMM_NONE;
      end
    end
  end

endmodule : ifd_opc_class

`default_nettype wire

/* ifd_pkg.sv */
// decoder package: register map, byte codes, types
// assumes one core clock and an aligned byte stream
`default_nettype none

package ifd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // software register map
  localparam logic [3:0]  REG_CTRL        = 4'h0;
  localparam logic [3:0]  REG_STATUS      = 4'h1;
  localparam logic [3:0]  REG_COUNT       = 4'h2;
  localparam logic [3:0]  REG_LAST        = 4'h3;
  localparam int          CTRL_EN_BIT     = 0;
  localparam int          CTRL_DFLAG_BIT  = 1;
  localparam int          CTRL_MODE_LSB   = 2;
  localparam logic [15:0] CTRL_RESET      = 16'h0001;
  localparam logic [1:0]  MODE_REAL       = 2'h0;
  localparam logic [1:0]  MODE_PROT       = 2'h1;
  localparam logic [1:0]  MODE_V86        = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // byte codes
  localparam logic [7:0]  PFX_OPSIZE      = 8'h66;
  localparam logic [7:0]  PFX_ADSIZE      = 8'h67;
  localparam logic [7:0]  PFX_LOCK        = 8'hf0;
  localparam logic [7:0]  PFX_SEG_ES      = 8'h26;
  localparam logic [7:0]  PFX_SEG_CS      = 8'h2e;
  localparam logic [7:0]  PFX_SEG_SS      = 8'h36;
  localparam logic [7:0]  PFX_SEG_DS      = 8'h3e;
  localparam logic [7:0]  PFX_SEG_FS      = 8'h64;
  localparam logic [7:0]  PFX_SEG_GS      = 8'h65;
  localparam logic [7:0]  OPC_ESCAPE      = 8'h0f;
  localparam logic [2:0]  RM_SIB          = 3'h4;
  localparam logic [2:0]  RM_D16_ONLY     = 3'h6;
  localparam logic [2:0]  BASE_D32_ONLY   = 3'h5;
  localparam logic [1:0]  MOD_REG         = 2'h3;
  localparam logic [2:0]  SEG3_LAST_VALID = 3'h5;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [2:0] {
    ST_OPC  = 3'b000,
    ST_OPC2 = 3'b001,
    ST_MODRM = 3'b010,
    ST_SIB  = 3'b011,
    ST_DISP = 3'b100,
    ST_IMM  = 3'b101
  } ifd_state_e;

  typedef enum logic [1:0] {
    IMM_NONE = 2'b00,
    IMM_BYTE = 2'b01,
    IMM_FULL = 2'b10,
    IMM_WORD = 2'b11
  } ifd_imm_e;

  typedef struct packed {
    logic     has_modrm;
    ifd_imm_e imm;
    logic     has_w;
    logic     has_d;
    logic     has_s;
    logic     has_cond;
    logic     has_seg2;
    logic     has_seg3;
    logic     has_opreg;
  } ifd_attr_s;

  typedef struct packed {
    logic [4:0]  length;
    logic        two_byte;
    logic [7:0]  opcode;
    logic        op32;
    logic        addr32;
    logic        lock;
    logic [1:0]  rep;
    logic        seg_ovr_valid;
    logic [2:0]  seg_ovr;
    logic        modrm_present;
    logic [1:0]  mode_field;
    logic [2:0]  reg_field;
    logic [2:0]  rm_field;
    logic        sib_present;
    logic [1:0]  scale;
    logic [2:0]  index;
    logic [2:0]  base;
    logic [2:0]  disp_len;
    logic [31:0] disp;
    logic [2:0]  imm_len;
    logic [31:0] imm;
    logic        w;
    logic        d;
    logic        s;
    logic        cond_valid;
    logic [3:0]  cond;
    logic        seg2_valid;
    logic [1:0]  seg_selector_two_bit;
    logic        seg3_valid;
    logic [2:0]  seg_selector_three_bit;
    logic [2:0]  dst_reg;
    logic        dst_high_byte;
    logic [3:0]  dst_byte_mask;
  } ifd_fields_s;

endpackage : ifd_pkg

`default_nettype wire

/* tb_instruction_format_decoder.sv */
// self-checking bench for ifd_decoder
// assumes a 200 MHz clock, sync active-high reset
`default_nettype none

module tb_instruction_format_decoder
  import ifd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_sys;
  logic        reset;
  logic        ce;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        byte_valid;
  logic [7:0]  byte_data;
  logic        byte_ready;
  logic        dec_valid;
  ifd_fields_s dec_fields;
  logic        slow;
  ifd_fields_s r[$];
  logic [7:0]  b[$];
  logic [15:0] d;
  int          miscompares;
  int          n_compared;

  ifd_decoder uut (
    .clk_sys(clk_sys), .reset(reset), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .byte_valid(byte_valid), .byte_data(byte_data), .byte_ready(byte_ready),
    .dec_valid(dec_valid), .dec_fields(dec_fields)
  );
  ifd_fetch_model fm (
    .clk_sys(clk_sys), .reset(reset), .ce(ce), .slow(slow),
    .byte_ready(byte_ready), .byte_valid(byte_valid), .byte_data(byte_data)
  );

  always #2.5 clk_sys = ~clk_sys;

  ////////////////////////////////////////
  task automatic cmp(input logic [63:0] g, input logic [63:0] e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp

  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    cmp(reg_rdata, e);
  endtask : rd

  // bounded: a hang ends the run
  task automatic go(input int n);
    r.delete();
    foreach (b[i]) fm.push(b[i]);
    for (int k = 0; k < 400 && r.size() < n; k++) begin
      @(posedge clk_sys);
      #1;
      if (dec_valid === 1'b1) r.push_back(dec_fields);
    end
    if (r.size() < n) begin
      miscompares++;
      give_verdict();
    end
  endtask : go

  ////////////////////////////////////////
  task automatic t_regs;
    rd(REG_CTRL, 16'h0001);
    wr(REG_COUNT, 16'h00ff);
    rd(REG_COUNT, 16'h0000);
    rd(4'hf, 16'h0000);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_sizes;
    logic [1:0] md[4];
    logic       w;
    md = '{MODE_REAL, MODE_PROT, MODE_PROT, MODE_V86};
    for (int i = 0; i < 4; i++) begin
      w = (i == 2);
      wr(REG_CTRL, {12'h000, md[i], i != 1, 1'b1});
      b = '{8'h05};
      repeat (w ? 4 : 2) b.push_back(8'h11);
      b.push_back(PFX_OPSIZE);
      b.push_back(8'h05);
      repeat (w ? 2 : 4) b.push_back(8'h22);
      b.push_back(PFX_ADSIZE);
      b.push_back(8'h90);
      go(3);
      cmp({r[0].op32, r[0].addr32}, w ? 32'h3 : 32'h0);
      cmp(r[0].imm, w ? 32'h11111111 : 32'h00001111);
      cmp({r[1].op32, r[1].length}, w ? 32'h04 : 32'h26);
      cmp({r[2].op32, r[2].addr32}, w ? 32'h2 : 32'h1);
    end
    $display("t_sizes done");
  endtask : t_sizes

  task automatic t_addr;
    wr(REG_CTRL, 16'h0001);
    b = '{8'h66, 8'h67, 8'h8b, 8'h4c, 8'h9d, 8'h08, 8'h67, 8'h66, 8'h8b, 8'h4c, 8'h9d,
          8'h08, 8'h8b, 8'h86, 8'hcd, 8'hab, 8'h67, 8'h8b, 8'h05, 8'h78, 8'h56, 8'h34,
          8'h12, 8'h67, 8'h8b, 8'hc4};
    go(5);
    for (int i = 0; i < 2; i++) begin
      cmp({r[i].length, r[i].op32, r[i].addr32, r[i].sib_present}, 32'h37);
      cmp({r[i].mode_field, r[i].reg_field, r[i].rm_field}, 32'h4c);
      cmp({r[i].scale, r[i].index, r[i].base}, 32'h9d);
      cmp({r[i].disp_len, r[i].disp}, 36'h100000008);
    end
    cmp({r[2].sib_present, r[2].disp_len, r[2].disp}, 36'h20000abcd);
    cmp({r[3].length, r[3].disp_len, r[3].disp}, 40'h3c12345678);
    cmp({r[4].length, r[4].sib_present}, 32'h6);
    $display("t_addr done");
  endtask : t_addr

  task automatic t_imm;
    b = '{8'h67, 8'h83, 8'h44, 8'h24, 8'h08, 8'h7f, 8'h80, 8'hc1, 8'h05, 8'h88, 8'hc1,
          8'h8b, 8'hd8, 8'h66, 8'h8b, 8'hd8, 8'h8a, 8'he1, 8'h8a, 8'hc1};
    go(7);
    cmp({r[0].length, r[0].disp_len, r[0].imm_len, r[0].imm[7:0]}, 32'h1897f);
    cmp({r[0].w, r[0].s, r[1].w, r[1].s}, 32'hc);
    cmp({r[1].length, r[1].imm_len, r[1].imm[7:0]}, 32'h1905);
    cmp({r[2].w, r[2].d, r[3].w, r[3].d}, 32'h3);
    cmp({r[2].dst_reg, r[2].dst_byte_mask}, 32'h11);
    cmp({r[3].dst_reg, r[3].dst_byte_mask}, 32'h33);
    cmp({r[4].dst_reg, r[4].dst_byte_mask}, 32'h3f);
    cmp({r[5].dst_high_byte, r[5].dst_reg, r[5].dst_byte_mask}, 32'h82);
    cmp({r[6].dst_high_byte, r[6].dst_reg, r[6].dst_byte_mask}, 32'h01);
    $display("t_imm done");
  endtask : t_imm

  task automatic t_fields;
    slow <= 1'b1;
    b.delete();
    for (int c = 0; c < 16; c++) b = {b, 8'h70 | 8'(c), 8'h00};
    for (int c = 0; c < 4; c++) b.push_back(8'h06 | 8'(c << 3));
    for (int c = 0; c < 8; c++) b = {b, 8'h8e, 8'hc0 | 8'(c << 3)};
    go(28);
    for (int c = 0; c < 16; c++) cmp({r[c].cond_valid, r[c].cond}, 32'h10 | c);
    for (int c = 0; c < 4; c++) begin
      cmp({r[16+c].seg2_valid, r[16+c].seg_selector_two_bit}, 32'h4 | c);
    end
    for (int c = 0; c < 8; c++) cmp(r[20+c].seg3_valid, c < 6);
    cmp(r[25].seg_selector_three_bit, 32'h5);
    wr(REG_CTRL, 16'h0007);
    b = '{OPC_ESCAPE, 8'h84, 8'h44, 8'h33, 8'h22, 8'h11};
    go(1);
    cmp({r[0].two_byte, r[0].cond_valid, r[0].cond, r[0].opcode}, 32'h3484);
    cmp(r[0].imm, 32'h11223344);
    rd(REG_LAST, 16'h0066);
    rd(REG_COUNT, 16'h0035);
    slow <= 1'b0;
    $display("t_fields done");
  endtask : t_fields

  ////////////////////////////////////////
  initial begin
    clk_sys     = 1'b0;
    reset       = 1'b1;
    ce          = 1'b1;
    reg_addr    = 4'h0;
    reg_wdata   = 16'h0000;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    slow        = 1'b0;
    miscompares = 0;
    n_compared  = 0;
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    t_regs();
    t_sizes();
    t_addr();
    t_imm();
    t_fields();
    give_verdict();
  end
endmodule : tb_instruction_format_decoder

`default_nettype wire
